// ===== bench/tb_usart_addr_filter_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tb_usart_addr_filter_regs
	import uaf_pkg::*;
;
	// stimulus
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        hsel_i = 1'b0;
	logic        hwrite_i = 1'b0;
	logic [1:0]  htrans_i = 2'h0;
	logic [31:0] haddr_i = 32'h0;
	logic [31:0] hwdata_i = 32'h0;
	logic        rx_frame_valid_i = 1'b0;
	logic [8:0]  rx_frame_data_i = 9'h000;
	logic        rx_first_stop_i = 1'b1;
	logic        rx_parity_err_i = 1'b0;
	logic        global_irq_enable_i = 1'b0;
	logic        tx_irq_taken_i = 1'b0;
	logic [7:0]  dly = 8'h00;
	// outputs
	wire         hrdy;
	wire         tx_shift_empty_i;
	wire         tx_frame_done_i;
	wire         tx_load_o;
	wire  [8:0]  tx_load_data_o;
	wire  [31:0] hrdata_o;
	wire  [2:0]  char_size_sel_o;
	wire  [11:0] baud_divisor_o;
	wire         two_stop_select_o;
	wire         rx_irq_o;
	wire         tx_irq_o;
	logic [8:0]  sent_q[$];
	logic [2:0]  ct[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
	logic [8:0]  mt[5] = '{9'h01F, 9'h03F, 9'h07F, 9'h0FF, 9'h1FF};
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          cyc = 0;

	uaf_top i_dut (.clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i,
		.hready_i(hrdy), .hrdata_o, .hreadyout_o(hrdy), .hresp_o(), .rx_frame_valid_i, .rx_frame_data_i,
		.rx_first_stop_i, .rx_parity_err_i, .tx_shift_empty_i, .tx_frame_done_i, .tx_load_o, .tx_load_data_o,
		.tx_active_o(), .rx_enable_o(), .char_size_sel_o, .two_stop_select_o, .parity_mode_o(), .sync_mode_o(),
		.clock_polarity_o(), .double_speed_sel_o(), .baud_divisor_o, .global_irq_enable_i, .tx_irq_taken_i,
		.rx_irq_o, .tx_irq_o, .dre_irq_o());
	uaf_far_node i_far (.clk_i, .reset_i, .load_i(tx_load_o), .dly_i(dly), .empty_o(tx_shift_empty_i),
		.done_o(tx_frame_done_i));

	// clock, hang guard and a log of what the shifter took
	initial forever #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (tx_load_o && tx_shift_empty_i)
			sent_q.push_back(tx_load_data_o);
		if (cyc == 20000) begin
			error_cnt++;
			$display("Error %0t: timeout", $time);
			end_of_test;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : chk

	// one single transfer; ready and read data are taken at the rising edge, before that edge's updates land
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		hwrite_i <= w;
		haddr_i <= {24'h0, a};
		do @(posedge clk_i); while (hrdy !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= {24'h0, d};
		do @(posedge clk_i); while (hrdy !== 1'b1);
		r = hrdata_o;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 8'h00, r);
		chk(r, e, "read");
	endtask : rd

	// one received frame; afterwards the data and stop lines show the inverse, not the old value
	task automatic frame(input logic [8:0] d, input logic stop, input logic pe);
		rx_frame_valid_i <= 1'b1;
		rx_frame_data_i <= d;
		rx_first_stop_i <= stop;
		rx_parity_err_i <= pe;
		@(posedge clk_i);
		rx_frame_valid_i <= 1'b0;
		rx_frame_data_i <= ~d;
		rx_first_stop_i <= ~stop;
		repeat (2) @(posedge clk_i);
	endtask : frame

	task automatic t_shared;
		rd(ADDR_CSA, 32'h20);
		rd(ADDR_SHARED, 32'h0);
		rd(ADDR_SHARED, {24'h0, CFG_RESET});
		rd(8'h14, 32'h0);
		wr(ADDR_SHARED, 8'h05);
		wr(ADDR_SHARED, 8'h8E);
		@(negedge clk_i);
		chk({28'h0, baud_divisor_o[11:8]}, 32'h5, "baud");
		chk({31'h0, two_stop_select_o}, 32'h1, "stops");
		@(posedge clk_i);
		rd(ADDR_SHARED, 32'h05);
		rd(ADDR_SHARED, 32'h8E);
		@(posedge clk_i);
		rd(ADDR_SHARED, 32'h05);
		rd(ADDR_CSA, 32'h20);
		rd(ADDR_SHARED, 32'h05);
		$display("shared location test done");
	endtask : t_shared

	task automatic t_sizes;
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_CSB, {5'b00011, ct[i][2], 2'b01});
			wr(ADDR_SHARED, {4'h8, 1'b1, ct[i][1:0], 1'b0});
			// the new size only shows once the write edge has settled
			@(negedge clk_i);
			chk({29'h0, char_size_sel_o}, {29'h0, ct[i]}, "size");
			@(posedge clk_i);
			wr(ADDR_DATA, 8'hFF);
			while (sent_q.size() < i + 1) @(posedge clk_i);
			chk({23'h0, sent_q[i]}, {23'h0, mt[i]}, "tx data");
			frame(9'h1FF, 1'b1, 1'b0);
			rd(ADDR_DATA, {24'h0, mt[i][7:0]});
		end
		$display("size test done");
	endtask : t_sizes

	task automatic t_filter;
		wr(ADDR_CSA, 8'h41);
		rd(ADDR_CSA, 32'h21);
		frame(9'h0A5, 1'b1, 1'b1);
		rd(ADDR_CSA, 32'h21);
		frame(9'h13C, 1'b1, 1'b0);
		rd(ADDR_CSA, 32'hA1);
		rd(ADDR_CSB, 32'h1F);
		rd(ADDR_DATA, 32'h3C);
		wr(ADDR_CSA, 8'h00);
		frame(9'h055, 1'b1, 1'b0);
		rd(ADDR_DATA, 32'h55);
		wr(ADDR_CSB, 8'h18);
		wr(ADDR_SHARED, 8'h8E);
		wr(ADDR_CSA, 8'h01);
		frame(9'h1AA, 1'b0, 1'b0);
		rd(ADDR_CSA, 32'h21);
		frame(9'h0AA, 1'b1, 1'b0);
		rd(ADDR_DATA, 32'hAA);
		wr(ADDR_CSA, 8'h00);
		$display("filter test done");
	endtask : t_filter

	task automatic t_fifo;
		frame(9'h011, 1'b1, 1'b0);
		frame(9'h022, 1'b1, 1'b0);
		frame(9'h033, 1'b1, 1'b0);
		rd(ADDR_CSA, 32'hA8);
		global_irq_enable_i <= 1'b1;
		wr(ADDR_CSB, 8'h98);
		@(negedge clk_i);
		chk({31'h0, rx_irq_o}, 32'h1, "rx irq");
		@(posedge clk_i);
		global_irq_enable_i <= 1'b0;
		@(negedge clk_i);
		chk({31'h0, rx_irq_o}, 32'h0, "rx irq gated");
		@(posedge clk_i);
		rd(ADDR_DATA, 32'h11);
		rd(ADDR_DATA, 32'h22);
		rd(ADDR_CSA, 32'h20);
		frame(9'h044, 1'b1, 1'b0);
		wr(ADDR_CSB, 8'h08);
		rd(ADDR_CSA, 32'h20);
		$display("fifo test done");
	endtask : t_fifo

	task automatic t_tx;
		int n;
		n = sent_q.size();
		dly <= 8'd20;
		global_irq_enable_i <= 1'b1;
		wr(ADDR_CSA, 8'h41);
		wr(ADDR_CSB, 8'h48);
		wr(ADDR_DATA, 8'h11);
		wr(ADDR_DATA, 8'h22);
		wr(ADDR_DATA, 8'h33);
		rd(ADDR_CSA, 32'h01);
		while (sent_q.size() < n + 2) @(posedge clk_i);
		repeat (30) @(posedge clk_i);
		chk(sent_q.size(), n + 2, "frames");
		chk({23'h0, sent_q[n]}, 32'h11, "first");
		chk({23'h0, sent_q[n + 1]}, 32'h22, "second");
		rd(ADDR_CSA, 32'h61);
		@(negedge clk_i);
		chk({31'h0, tx_irq_o}, 32'h1, "tx irq");
		@(posedge clk_i);
		tx_irq_taken_i <= 1'b1;
		@(posedge clk_i);
		tx_irq_taken_i <= 1'b0;
		@(negedge clk_i);
		chk({31'h0, tx_irq_o}, 32'h0, "tx irq taken");
		@(posedge clk_i);
		$display("transmit test done");
	endtask : t_tx

	task automatic end_of_test;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	// reset, then the scenarios in order
	initial begin
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		t_shared;
		t_sizes;
		t_filter;
		t_fifo;
		t_tx;
		end_of_test;
	end
endmodule : tb_usart_addr_filter_regs

`default_nettype wire

// ===== bench/uaf_far_node.sv
`timescale 1ns/1ps
`default_nettype none

module uaf_far_node (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// shifter handshake; dly_i sets how slowly a frame goes out
	input  wire logic       load_i,
	input  wire logic [7:0] dly_i,
	output logic            empty_o,
	output logic            done_o
);
	logic [7:0] cnt;
	// the shifter only takes a frame while empty, and says so when it is out
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (reset_i) begin
			empty_o <= 1'b1;
			cnt <= 8'h00;
		end else if (load_i && empty_o) begin
			empty_o <= 1'b0;
			cnt <= dly_i;
		end else if (!empty_o) begin
			if (cnt == 8'h00) begin
				empty_o <= 1'b1;
				done_o <= 1'b1;
			end else begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule : uaf_far_node

`default_nettype wire

// ===== bench/uaf_top_props.sv
`timescale 1ns/1ps
`default_nettype none

module uaf_top_props (
	// clock, reset and bus
	input wire logic       clk_i,
	input wire logic       reset_i,
	input wire logic       hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic       hwrite_i,
	input wire logic       hready_i,
	input wire logic       hreadyout_o,
	input wire logic       hresp_o,
	// transmit side and interrupts
	input wire logic       tx_load_o,
	input wire logic       tx_shift_empty_i,
	input wire logic       tx_frame_done_i,
	input wire logic       tx_irq_taken_i,
	input wire logic       rx_enable_o,
	input wire logic       global_irq_enable_i,
	input wire logic       rx_irq_o,
	input wire logic       tx_irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic take_w;
	// a transfer is taken only when selected, requested and the bus is ready
	assign take_w = hsel_i & htrans_i[1] & hready_i;
	a_resp_okay: assert property (hresp_o == 1'b0)
		else $error("bus response not okay");
	a_read_wait: assert property (take_w && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take_w && hwrite_i |=> hreadyout_o)
		else $error("write stalled");
	a_load_empty: assert property (tx_load_o |-> tx_shift_empty_i)
		else $error("load into busy shifter");
	a_load_once: assert property (tx_load_o |=> !tx_load_o)
		else $error("buffer loaded twice");
	a_irq_gate: assert property (rx_irq_o || tx_irq_o |-> global_irq_enable_i)
		else $error("irq without global enable");
	a_rx_flush: assert property (!rx_enable_o && $past(rx_enable_o) == 1'b0 |-> !rx_irq_o)
		else $error("receive flag kept while disabled");
	a_txc_clear: assert property (tx_irq_taken_i && !tx_frame_done_i |=> !tx_irq_o)
		else $error("tx complete not cleared");
endmodule : uaf_top_props

bind uaf_top uaf_top_props i_props (.clk_i, .reset_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i, .hreadyout_o,
	.hresp_o, .tx_load_o, .tx_shift_empty_i, .tx_frame_done_i, .tx_irq_taken_i, .rx_enable_o,
	.global_irq_enable_i, .rx_irq_o, .tx_irq_o);

`default_nettype wire

// ===== common/uaf_pkg.sv
package uaf_pkg;

	// register byte addresses on the bus (low address bits only)
	localparam int         ADDR_W        = 8;
	localparam logic [7:0] ADDR_DATA     = 8'h00;
	localparam logic [7:0] ADDR_CSA      = 8'h04;
	localparam logic [7:0] ADDR_CSB      = 8'h08;
	localparam logic [7:0] ADDR_SHARED   = 8'h0C;
	localparam logic [7:0] ADDR_BAUD_LO  = 8'h10;

	// ctrl_status_a bit positions
	localparam int CSA_RXC  = 7;
	localparam int CSA_TXC  = 6;
	localparam int CSA_DRE  = 5;
	localparam int CSA_FE   = 4;
	localparam int CSA_DOR  = 3;
	localparam int CSA_PE   = 2;
	localparam int CSA_U2X  = 1;
	localparam int CSA_ADDRESS_FILTER_MODE = 0;

	// ctrl_status_b bit positions
	localparam int CSB_RX_DONE_IRQ_ENABLE = 7;
	localparam int CSB_TX_DONE_IRQ_ENABLE = 6;
	localparam int CSB_DREIE = 5;
	localparam int CSB_RXEN  = 4;
	localparam int CSB_TXEN  = 3;
	localparam int CSB_CSZ2  = 2;
	localparam int CSB_RX_NINTH_BIT  = 1;
	localparam int CSB_TX_NINTH_BIT  = 0;

	// shared location: select bit and frame_config fields
	localparam int CFG_SEL     = 7;
	localparam int CFG_UMSEL   = 6;
	localparam int CFG_UPM_HI  = 5;
	localparam int CFG_UPM_LO  = 4;
	localparam int CFG_TWO_STOP_SELECT    = 3;
	localparam int CFG_CSZ_HI  = 2;
	localparam int CFG_CSZ_LO  = 1;
	localparam int CFG_UCPOL   = 0;
	localparam logic [7:0] CFG_RESET   = 8'h86;
	localparam int         BAUD_HI_W   = 4;

	// character size codes
	localparam logic [2:0] CSZ_5 = 3'h0;
	localparam logic [2:0] CSZ_6 = 3'h1;
	localparam logic [2:0] CSZ_7 = 3'h2;
	localparam logic [2:0] CSZ_9 = 3'h7;

	// widths
	localparam int FRAME_W = 9;
	localparam int ENTRY_W = 11;
	localparam int ENT_FE  = 10;
	localparam int ENT_PE  = 9;
	localparam int ENT_B8  = 8;

	// bus encodings
	localparam logic       HRESP_OKAY = 1'b0;

	// keep only the bits the character size uses; upper bits become zero
	function automatic logic [8:0] uaf_mask(input logic [2:0] csz, input logic [8:0] d);
		logic [8:0] m;
		m = 9'h0FF;
		unique case (csz)
			CSZ_5:   m = 9'h01F;
			CSZ_6:   m = 9'h03F;
			CSZ_7:   m = 9'h07F;
			CSZ_9:   m = 9'h1FF;
			default: m = 9'h0FF;
		endcase
		return d & m;
	endfunction : uaf_mask

endpackage : uaf_pkg

// ===== src/uaf_rx_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module uaf_rx_fifo #(
	parameter int WIDTH = 11
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	// control
	input  wire logic             flush_i,
	input  wire logic             push_i,
	input  wire logic [WIDTH-1:0] push_data_i,
	input  wire logic             pop_i,
	// status
	output logic      [WIDTH-1:0] head_o,
	output logic                  empty_o,
	output logic                  full_o
);

	logic [WIDTH-1:0] mem_q [2];
	logic [WIDTH-1:0] mem_d [2];
	logic             rd_ptr_q, rd_ptr_d;
	logic [1:0]       count_q, count_d;
	logic             do_push, do_pop;

	assign empty_o = (count_q == 2'h0);
	assign full_o  = (count_q == 2'h2);
	assign head_o  = mem_q[rd_ptr_q];

	// pointer and occupancy; a push into a full fifo is refused here
	always_comb begin
		do_push  = push_i && !full_o;
		do_pop   = pop_i && !empty_o;
		mem_d    = mem_q;
		rd_ptr_d = rd_ptr_q;
		count_d  = count_q;
		if (do_push) begin
			mem_d[rd_ptr_q ^ count_q[0]] = push_data_i;
		end
		if (do_pop) begin
			rd_ptr_d = !rd_ptr_q;
		end
		count_d = count_q + {1'b0, do_push} - {1'b0, do_pop};
		if (flush_i) begin
			rd_ptr_d = 1'b0;
			count_d  = 2'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			rd_ptr_q <= 1'b0;
			count_q  <= 2'h0;
		end else begin
			mem_q    <= mem_d;
			rd_ptr_q <= rd_ptr_d;
			count_q  <= count_d;
		end
	end

endmodule : uaf_rx_fifo

`default_nettype wire

// ===== src/uaf_top.sv
// Functional notes
// - with filter mode on, data frames are dropped and never stored.
// - transmitter behaves the same regardless of filter mode.
// - frame type comes from first stop bit, or ninth bit in 9-bit mode.
// - frame type one is address, zero is data.
// - address frames are stored and raise receive complete as usual.
// - write to shared location picks divisor high or frame config by bit 7.
// - single read gives divisor high; read right after a shared read gives config.
// - data writes go to transmit buffer; data reads return receive buffer.
// - unused upper bits are dropped on transmit and read as zero.
// - data write while transmit buffer is full is ignored.
// - enabled transmitter moves buffer into empty shift register.
// - receive buffer is a two-entry fifo advanced by every data read.
// - receive complete mirrors unread data; receiver disable flushes it.
// - tx complete sets when frame done and transmit buffer empty.
// - tx complete clears on interrupt taken or writing one to it.
// - rx and tx complete flags are interrupt request sources.
// - interrupts need own enable, global enable and the flag.
// - char size 0 to 3 select 5 to 8 bits, 7 selects 9 bits.
// - transmit buffer empty reads one when writable and after reset.
`timescale 1ns/1ps
`default_nettype none

module uaf_top
	import uaf_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// ahb-lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// receive frame recovery side
	input  wire logic        rx_frame_valid_i,
	input  wire logic [8:0]  rx_frame_data_i,
	input  wire logic        rx_first_stop_i,
	input  wire logic        rx_parity_err_i,
	// transmit shifter side
	input  wire logic        tx_shift_empty_i,
	input  wire logic        tx_frame_done_i,
	output logic             tx_load_o,
	output logic      [8:0]  tx_load_data_o,
	output logic             tx_active_o,
	// configuration to baud and frame logic
	output logic             rx_enable_o,
	output logic      [2:0]  char_size_sel_o,
	output logic             two_stop_select_o,
	output logic      [1:0]  parity_mode_o,
	output logic             sync_mode_o,
	output logic             clock_polarity_o,
	output logic             double_speed_sel_o,
	output logic      [11:0] baud_divisor_o,
	// interrupt requests
	input  wire logic        global_irq_enable_i,
	input  wire logic        tx_irq_taken_i,
	output logic             rx_irq_o,
	output logic             tx_irq_o,
	output logic             dre_irq_o
);

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WRITE,
		BUS_RD_FETCH,
		BUS_RD_DONE
	} uaf_bus_state_t;

	// bus group
	uaf_bus_state_t    state_q, state_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic              cfg_read_q, cfg_read_d;
	logic              shared_arm_q, shared_arm_d;
	logic [31:0]       hrdata_q, hrdata_d;
	logic              accept;
	logic              follow_read;
	logic              wr_en;
	logic [7:0]        wdata;

	// configuration group
	logic [7:0]           csb_q, csb_d;
	logic [7:0]           cfg_q, cfg_d;
	logic [BAUD_HI_W-1:0] baud_hi_q, baud_hi_d;
	logic [7:0]           baud_lo_q, baud_lo_d;
	logic                 u2x_q, u2x_d;
	logic                 address_filter_mode_q, address_filter_mode_d;
	logic [2:0]           csz;

	// transmit and receive group
	logic             txc_q, txc_d;
	logic             tx_full_q, tx_full_d;
	logic [8:0]       tx_buf_q, tx_buf_d;
	logic             tx_on_q, tx_on_d;
	logic             dor_q, dor_d;
	logic             tx_move;
	logic             frame_type;
	logic             frame_keep;
	logic             fifo_push;
	logic             fifo_pop;
	logic [ENTRY_W-1:0] fifo_head;
	logic [ENTRY_W-1:0] fifo_entry;
	logic             fifo_empty;
	logic             fifo_full;
	logic [7:0]       csa_rd;
	logic             rx_complete_flag;

	// address phase is taken only when the bus is ready and a transfer is requested
	assign accept      = hsel_i && htrans_i[1] && hready_i;
	assign wr_en       = (state_q == BUS_WRITE);
	assign wdata       = hwdata_i[7:0];
	// a read counts as following only with at most one idle cycle since the last shared read
	assign follow_read = shared_arm_q || (state_q == BUS_RD_DONE && addr_q == ADDR_SHARED);
	// reads fetch into a flop first, which costs one wait state
	assign hreadyout_o = (state_q != BUS_RD_FETCH);
	assign hresp_o     = HRESP_OKAY;
	assign hrdata_o    = hrdata_q;
	assign fifo_pop    = (state_q == BUS_RD_FETCH) && (addr_q == ADDR_DATA);

	// status a as software sees it
	assign rx_complete_flag    = !fifo_empty;
	assign csa_rd = {rx_complete_flag, txc_q, !tx_full_q, fifo_head[ENT_FE], dor_q, fifo_head[ENT_PE], u2x_q, address_filter_mode_q};

	// bus state, timed shared read sequence and read data
	always_comb begin
		state_d      = state_q;
		addr_d       = addr_q;
		cfg_read_d   = cfg_read_q;
		hrdata_d     = hrdata_q;
		shared_arm_d = (state_q == BUS_RD_DONE) && (addr_q == ADDR_SHARED);
		unique case (state_q)
			BUS_IDLE, BUS_WRITE, BUS_RD_DONE: begin
				state_d = BUS_IDLE;
				if (accept) begin
					addr_d     = haddr_i[ADDR_W-1:0];
					state_d    = hwrite_i ? BUS_WRITE : BUS_RD_FETCH;
					cfg_read_d = !hwrite_i && follow_read;
				end
			end
			BUS_RD_FETCH: begin
				state_d  = BUS_RD_DONE;
				hrdata_d = 32'h0000_0000;
				unique case (addr_q)
					ADDR_DATA:    hrdata_d[7:0] = fifo_head[7:0];
					ADDR_CSA:     hrdata_d[7:0] = csa_rd;
					ADDR_CSB:     hrdata_d[7:0] = {csb_q[7:2], fifo_head[ENT_B8], csb_q[CSB_TX_NINTH_BIT]};
					ADDR_SHARED:  hrdata_d[7:0] = cfg_read_q ? {1'b1, cfg_q[6:0]} :
						{{(8-BAUD_HI_W){1'b0}}, baud_hi_q};
					ADDR_BAUD_LO: hrdata_d[7:0] = baud_lo_q;
					default:      hrdata_d[7:0] = 8'h00; // unmapped reads zero, still OKAY
				endcase
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_q      <= BUS_IDLE;
			addr_q       <= '0;
			cfg_read_q   <= 1'b0;
			shared_arm_q <= 1'b0;
			hrdata_q     <= 32'h0000_0000;
		end else begin
			state_q      <= state_d;
			addr_q       <= addr_d;
			cfg_read_q   <= cfg_read_d;
			shared_arm_q <= shared_arm_d;
			hrdata_q     <= hrdata_d;
		end
	end

	// configuration registers written in the write data phase
	always_comb begin
		csb_d     = csb_q;
		cfg_d     = cfg_q;
		baud_hi_d = baud_hi_q;
		baud_lo_d = baud_lo_q;
		u2x_d     = u2x_q;
		address_filter_mode_d    = address_filter_mode_q;
		if (wr_en) begin
			unique case (addr_q)
				ADDR_CSA: begin
					u2x_d  = wdata[CSA_U2X];
					address_filter_mode_d = wdata[CSA_ADDRESS_FILTER_MODE];
				end
				ADDR_CSB: csb_d = {wdata[7:2], 1'b0, wdata[CSB_TX_NINTH_BIT]};
				ADDR_SHARED: begin
					if (wdata[CFG_SEL]) begin
						cfg_d = {1'b1, wdata[6:0]};
					end else begin
						baud_hi_d = wdata[BAUD_HI_W-1:0];
					end
				end
				ADDR_BAUD_LO: baud_lo_d = wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			csb_q     <= 8'h00;
			cfg_q     <= CFG_RESET;
			baud_hi_q <= '0;
			baud_lo_q <= 8'h00;
			u2x_q     <= 1'b0;
			address_filter_mode_q    <= 1'b0;
		end else begin
			csb_q     <= csb_d;
			cfg_q     <= cfg_d;
			baud_hi_q <= baud_hi_d;
			baud_lo_q <= baud_lo_d;
			u2x_q     <= u2x_d;
			address_filter_mode_q    <= address_filter_mode_d;
		end
	end

	// character size: codes 0..3 give 5..8 bits, 7 gives 9, others reserved
	assign csz = {csb_q[CSB_CSZ2], cfg_q[CFG_CSZ_HI:CFG_CSZ_LO]};

	// configuration outputs
	assign rx_enable_o        = csb_q[CSB_RXEN];
	assign char_size_sel_o    = csz;
	assign two_stop_select_o  = cfg_q[CFG_TWO_STOP_SELECT];
	assign parity_mode_o      = cfg_q[CFG_UPM_HI:CFG_UPM_LO];
	assign sync_mode_o        = cfg_q[CFG_UMSEL];
	assign clock_polarity_o   = cfg_q[CFG_UCPOL];
	assign double_speed_sel_o = u2x_q;
	assign baud_divisor_o     = {baud_hi_q, baud_lo_q};

	// frame type bit: ninth bit in 9-bit mode, else the first stop bit
	assign frame_type = (csz == CSZ_9) ? rx_frame_data_i[ENT_B8] : rx_first_stop_i;
	// one marks an address frame; data frames pass only with the filter off
	assign frame_keep = !address_filter_mode_q || frame_type;
	assign fifo_push  = rx_frame_valid_i && csb_q[CSB_RXEN] && frame_keep;
	// a stop bit of zero is a framing error; unused upper bits stored as zero
	assign fifo_entry = {!rx_first_stop_i, rx_parity_err_i, uaf_mask(csz, rx_frame_data_i)};

	// two-entry receive fifo, flushed while the receiver is off
	uaf_rx_fifo #(
		.WIDTH (ENTRY_W)
	) u_rx_fifo (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.flush_i     (!csb_q[CSB_RXEN]),
		.push_i      (fifo_push),
		.push_data_i (fifo_entry),
		.pop_i       (fifo_pop),
		.head_o      (fifo_head),
		.empty_o     (fifo_empty),
		.full_o      (fifo_full)
	);

	// buffer to shifter hand-off; filter mode plays no part here
	assign tx_move        = tx_on_q && tx_full_q && tx_shift_empty_i;
	assign tx_load_o      = tx_move;
	assign tx_load_data_o = tx_buf_q;
	assign tx_active_o    = tx_on_q;

	// transmit buffer, complete flag and overrun
	always_comb begin
		tx_buf_d  = tx_buf_q;
		tx_full_d = tx_full_q;
		txc_d     = txc_q;
		dor_d     = dor_q;
		tx_on_d   = tx_on_q;
		// disabling waits until the buffer and the shifter have drained
		if (csb_q[CSB_TXEN]) begin
			tx_on_d = 1'b1;
		end else if (!tx_full_q && tx_shift_empty_i) begin
			tx_on_d = 1'b0;
		end
		if (tx_move) begin
			tx_full_d = 1'b0;
		end
		// a write while the buffer is full leaves the pending data untouched
		if (wr_en && addr_q == ADDR_DATA && !tx_full_q) begin
			tx_buf_d  = uaf_mask(csz, {csb_q[CSB_TX_NINTH_BIT], wdata});
			tx_full_d = 1'b1;
		end
		// clears first so that a done event in the same cycle wins
		if (tx_irq_taken_i || (wr_en && addr_q == ADDR_CSA && wdata[CSA_TXC])) begin
			txc_d = 1'b0;
		end
		if (tx_frame_done_i && !tx_full_q) begin
			txc_d = 1'b1;
		end
		// overrun is valid until the next data read; no new overrun is set in the cycle of that read
		if (fifo_pop) begin
			dor_d = 1'b0;
		end
		if (rx_frame_valid_i && csb_q[CSB_RXEN] && frame_keep && fifo_full && !fifo_pop) begin
			dor_d = 1'b1;
		end
		if (!csb_q[CSB_RXEN]) begin
			dor_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tx_buf_q  <= '0;
			tx_full_q <= 1'b0;
			txc_q     <= 1'b0;
			dor_q     <= 1'b0;
			tx_on_q   <= 1'b0;
		end else begin
			tx_buf_q  <= tx_buf_d;
			tx_full_q <= tx_full_d;
			txc_q     <= txc_d;
			dor_q     <= dor_d;
			tx_on_q   <= tx_on_d;
		end
	end

	// interrupt requests, gated by own enable and the global enable
	assign rx_irq_o  = csb_q[CSB_RX_DONE_IRQ_ENABLE] && global_irq_enable_i && rx_complete_flag;
	assign tx_irq_o  = csb_q[CSB_TX_DONE_IRQ_ENABLE] && global_irq_enable_i && txc_q;
	assign dre_irq_o = csb_q[CSB_DREIE] && global_irq_enable_i && !tx_full_q;

endmodule : uaf_top

`default_nettype wire
